// ### include/lwsw_map.svh
// register addresses, bit positions and reset values of the latched warning status block
// assumes: included by bare name; defines only, no logic
`ifndef LWSW_MAP_SVH
`define LWSW_MAP_SVH

// ==========================================================
// parameter addresses seen by the fieldbus side
`define LWSW_ADDR_ACTION_STATUS 16'h1c08
`define LWSW_ADDR_SAVED_WARNING 16'h1c18

// ==========================================================
// saved warning word bit positions
`define LWSW_BIT_GENERAL 0
`define LWSW_BIT_STAGE_TEMP 1
`define LWSW_BIT_MOTOR_TEMP 2
`define LWSW_BIT_STAGE_I2T 4
`define LWSW_BIT_MOTOR_I2T 5
`define LWSW_BIT_BRAKE_I2T 6
`define LWSW_BIT_CAN 7
`define LWSW_BIT_ENCODER 8
`define LWSW_BIT_RS485 9
`define LWSW_BIT_TORQUE_OFF 10
`define LWSW_BIT_UNDERVOLT 11
`define LWSW_BIT_PROFIBUS 12
`define LWSW_BIT_POS_INVALID 13
`define LWSW_BIT_ETHERNET 14

// bits that follow their condition instead of latching (10, 11, 13)
`define LWSW_SELF_CLEAR_MASK 16'h2c00
// reserved bits 3 and 15 read as zero
`define LWSW_RESERVED_MASK 16'h8008

// ==========================================================
// action status word bit positions
`define LWSW_ACT_WARNING 0
`define LWSW_ACT_ERR_CLASS_LO 1
`define LWSW_ACT_STANDSTILL 6
`define LWSW_ACT_CW 7
`define LWSW_ACT_CCW 8
`define LWSW_ACT_PROFILE_LO 11

// ==========================================================
// reset values
`define LWSW_RESET_WORD 16'h0000

`endif

// ### include/lwsw_pkg.sv
// types shared by the latched warning status block
// assumes: compiled before any design module
package lwsw_pkg;

  // ==========================================================
  // profile generator state as reported by the motion core
  typedef enum logic [1:0] {
    LWSW_PROF_IDLE,
    LWSW_PROF_DECEL,
    LWSW_PROF_ACCEL,
    LWSW_PROF_CONST
  } lwsw_prof_t;

  // ==========================================================
  // complete state of the top module
  typedef struct packed {
    logic [15:0] saved;
    logic [15:0] action;
    logic fault_req_prev;
    logic [15:0] rd_data;
    logic rd_valid;
    logic rd_err;
    logic wr_err;
  } lwsw_state_t;

endpackage

// ### hw/lwsw_sync.sv
// two flip-flop synchroniser for a vector of asynchronous levels
// assumes: inputs are quasi-static levels; each bit is crossed on its own
`timescale 1ns/1ps

module lwsw_sync #(
  parameter int W = 1
) (
  input wire logic clock,
  input wire logic rst,
  input wire logic [W-1:0] din,
  output logic [W-1:0] dout
);

  typedef struct packed {
    logic [W-1:0] meta;
    logic [W-1:0] stable;
  } lwsw_sync_state_t;

  lwsw_sync_state_t s_q;
  lwsw_sync_state_t s_d;

  // ==========================================================
  // next state: first stage is read only by the second
  always_comb begin
    s_d.meta = din;
    s_d.stable = s_q.meta;
  end

  // state register
  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      s_q <= '0;
    end else begin
      s_q <= s_d;
    end
  end

  assign dout = s_q.stable;

endmodule

// ### hw/lwsw_top.sv
// latched warning status word and action status word, read by the fieldbus
// assumes: condition and request inputs are asynchronous levels from drive logic;
// the parameter port below is driven synchronously to clock by the fieldbus slave
//
// Overview of operation
// - 16-bit read-only saved warning word at address 7192; bits latch when set.
// - a carried-out fault reset request clears all saved warning bits whose condition is no longer present.
// - bits 10, 11 and 13 clear themselves once their condition ends.
// - bit 0 general warning, bit 1 power stage hot, bit 2 motor hot.
// - bits 4, 5, 6 flag overload of power stage, motor, braking resistor.
// - bit 7 CAN, bit 9 RS485, bit 12 Profibus, bit 14 Ethernet warning.
// - bit 10 safe torque off, bit 11 undervoltage or phase loss, bit 13 position invalid.
// - bit 8 motor encoder warning; bits 3 and 15 reserved.
// - action status word at 7176: warning, error classes, motion, profile state.
`timescale 1ns/1ps
`include "lwsw_map.svh"

module lwsw_top
  import lwsw_pkg::*;
#(
  parameter int NUM_ERR_CLASS = 4
) (
  input wire logic clock,
  input wire logic rst,
  // warning conditions, active high unless named otherwise
  input wire logic general_warn,
  input wire logic stage_temp_high,
  input wire logic motor_temp_high,
  input wire logic stage_overload,
  input wire logic motor_overload,
  input wire logic brake_overload,
  input wire logic can_warn,
  input wire logic encoder_warn,
  input wire logic rs485_warn,
  input wire logic safe_torque_off_input_a_n,
  input wire logic safe_torque_off_input_b_n,
  input wire logic dc_undervoltage,
  input wire logic mains_phase_missing,
  input wire logic profibus_warn,
  input wire logic position_not_valid,
  input wire logic ethernet_warn,
  // fault reset request level; its rising edge carries out the reset
  input wire logic fault_reset_request,
  // action status sources
  input wire logic [NUM_ERR_CLASS-1:0] error_class,
  input wire logic standstill,
  input wire logic rotate_cw,
  input wire logic rotate_ccw,
  input wire logic [1:0] profile_state,
  // parameter access port from the fieldbus slave
  input wire logic param_rd,
  input wire logic param_wr,
  input wire logic [15:0] param_addr,
  input wire logic [15:0] param_wdata,
  output logic [15:0] param_rdata,
  output logic param_rvalid,
  output logic param_err,
  output logic param_wr_refused
);

  localparam int NUM_SYNC = 16 + 1 + NUM_ERR_CLASS + 3 + 2;

  lwsw_state_t st_q;
  lwsw_state_t st_d;
  logic [NUM_SYNC-1:0] raw_in;
  logic [NUM_SYNC-1:0] sync_in;
  logic [15:0] cond;
  logic fault_req;
  logic [NUM_ERR_CLASS-1:0] err_class_s;
  logic [2:0] motion_s;
  lwsw_prof_t prof_s;

  // ==========================================================
  // one-hot decode of the profile generator state for bits 11..14
  function automatic logic [3:0] prof_onehot(input lwsw_prof_t p);
    logic [3:0] r;
    r = 4'h0;
    case (p)
      LWSW_PROF_IDLE: r = 4'h1;
      LWSW_PROF_DECEL: r = 4'h2;
      LWSW_PROF_ACCEL: r = 4'h4;
      LWSW_PROF_CONST: r = 4'h8;
      default: r = 4'h0;
    endcase
    return r;
  endfunction

  // ==========================================================
  // gather raw pin levels into warning-word positions
  always_comb begin
    raw_in = '0;
    raw_in[`LWSW_BIT_GENERAL] = general_warn;
    raw_in[`LWSW_BIT_STAGE_TEMP] = stage_temp_high;
    raw_in[`LWSW_BIT_MOTOR_TEMP] = motor_temp_high;
    raw_in[`LWSW_BIT_STAGE_I2T] = stage_overload;
    raw_in[`LWSW_BIT_MOTOR_I2T] = motor_overload;
    raw_in[`LWSW_BIT_BRAKE_I2T] = brake_overload;
    raw_in[`LWSW_BIT_CAN] = can_warn;
    raw_in[`LWSW_BIT_ENCODER] = encoder_warn;
    raw_in[`LWSW_BIT_RS485] = rs485_warn;
    // either safe torque off input pulled low
    raw_in[`LWSW_BIT_TORQUE_OFF] = ~safe_torque_off_input_a_n | ~safe_torque_off_input_b_n;
    raw_in[`LWSW_BIT_UNDERVOLT] = dc_undervoltage | mains_phase_missing;
    raw_in[`LWSW_BIT_PROFIBUS] = profibus_warn;
    raw_in[`LWSW_BIT_POS_INVALID] = position_not_valid;
    raw_in[`LWSW_BIT_ETHERNET] = ethernet_warn;
    raw_in[16] = fault_reset_request;
    raw_in[17 +: NUM_ERR_CLASS] = error_class;
    raw_in[17 + NUM_ERR_CLASS +: 3] = {rotate_ccw, rotate_cw, standstill};
    raw_in[20 + NUM_ERR_CLASS +: 2] = profile_state;
  end

  // ==========================================================
  // every asynchronous level crosses two flops before use
  lwsw_sync #(
    .W(NUM_SYNC)
  ) u_sync (
    .clock(clock),
    .rst(rst),
    .din(raw_in),
    .dout(sync_in)
  );

  // split the synchronised vector; reserved positions forced low
  always_comb begin
    cond = sync_in[15:0] & ~`LWSW_RESERVED_MASK;
    fault_req = sync_in[16];
    err_class_s = sync_in[17 +: NUM_ERR_CLASS];
    motion_s = sync_in[17 + NUM_ERR_CLASS +: 3];
    prof_s = lwsw_prof_t'(sync_in[20 + NUM_ERR_CLASS +: 2]);
  end

  // ==========================================================
  // next state of the status words and the access port
  always_comb begin
    logic clear_now;
    logic [15:0] latched;
    logic [15:0] rd_word;
    logic rd_hit;
    clear_now = 1'b0;
    latched = 16'h0000;
    rd_word = 16'h0000;
    rd_hit = 1'b0;
    st_d = st_q;

    // fault reset takes effect once per request edge, not while held
    st_d.fault_req_prev = fault_req;
    clear_now = fault_req & ~st_q.fault_req_prev;

    // latched bits: a condition present in the clear cycle survives it
    latched = clear_now ? 16'h0000 : st_q.saved;
    latched = latched | cond;
    // self-clearing bits simply follow their condition
    st_d.saved = (latched & ~`LWSW_SELF_CLEAR_MASK) | (cond & `LWSW_SELF_CLEAR_MASK);
    st_d.saved = st_d.saved & ~`LWSW_RESERVED_MASK;

    // action status word rebuilt every cycle from live sources
    st_d.action = 16'h0000;
    st_d.action[`LWSW_ACT_WARNING] = |cond;
    st_d.action[`LWSW_ACT_ERR_CLASS_LO +: NUM_ERR_CLASS] = err_class_s;
    st_d.action[`LWSW_ACT_STANDSTILL] = motion_s[0];
    st_d.action[`LWSW_ACT_CW] = motion_s[1];
    st_d.action[`LWSW_ACT_CCW] = motion_s[2];
    st_d.action[`LWSW_ACT_PROFILE_LO +: 4] = prof_onehot(prof_s);

    // read decode; the answer shows the words as stored last cycle
    case (param_addr)
      `LWSW_ADDR_SAVED_WARNING: begin
        rd_word = st_q.saved;
        rd_hit = 1'b1;
      end
      `LWSW_ADDR_ACTION_STATUS: begin
        rd_word = st_q.action;
        rd_hit = 1'b1;
      end
      default: begin
        rd_word = 16'h0000;
        rd_hit = 1'b0;
      end
    endcase

    // read wins over write if both strobes come together
    st_d.rd_valid = param_rd;
    st_d.rd_data = param_rd ? rd_word : 16'h0000;
    st_d.rd_err = (param_rd & ~rd_hit) | (param_wr & ~param_rd & ~rd_hit);
    // both words are read-only: the write data is dropped unseen
    st_d.wr_err = param_wr & ~param_rd & rd_hit;
  end

  // ==========================================================
  // state register; everything clears to zero at reset
  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      st_q.saved <= `LWSW_RESET_WORD;
      st_q.action <= `LWSW_RESET_WORD;
      st_q.fault_req_prev <= 1'b0;
      st_q.rd_data <= 16'h0000;
      st_q.rd_valid <= 1'b0;
      st_q.rd_err <= 1'b0;
      st_q.wr_err <= 1'b0;
    end else begin
      st_q <= st_d;
    end
  end

  // ==========================================================
  // outputs straight from the state register
  assign param_rdata = st_q.rd_data;
  assign param_rvalid = st_q.rd_valid;
  assign param_err = st_q.rd_err;
  assign param_wr_refused = st_q.wr_err;

  // write data is accepted on the port only to be discarded
  logic unused_wdata;
  assign unused_wdata = ^param_wdata;

endmodule

// ### tb/lwsw_monitor.sv
// port checker for the warning status block
// assumes: bound into lwsw_top, one clock domain, reset active high
`timescale 1ns/1ps
`include "lwsw_map.svh"
module lwsw_monitor (
  input wire logic clock,
  input wire logic rst,
  input wire logic safe_torque_off_input_a_n,
  input wire logic position_not_valid,
  input wire logic param_rd,
  input wire logic param_wr,
  input wire logic [15:0] param_addr,
  input wire logic [15:0] param_rdata,
  input wire logic param_rvalid,
  input wire logic param_err,
  input wire logic param_wr_refused
);
  // ==========================================================
  // decode and steps, five cycles covers the sync latency
  default clocking cb @(posedge clock); endclocking
  default disable iff (rst);
  wire is_map = param_addr == `LWSW_ADDR_SAVED_WARNING || param_addr == `LWSW_ADDR_ACTION_STATUS;
  sequence rd_saved; param_rd && param_addr == `LWSW_ADDR_SAVED_WARNING; endsequence
  sequence torque_off_on; !safe_torque_off_input_a_n [*5]; endsequence
  sequence pos_gone; !position_not_valid [*5]; endsequence
  // ==========================================================
  // assertions
  chk_read_answer: assert property (param_rd && is_map |=> param_rvalid && !param_err)
    else $error("mapped read got no answer");
  chk_no_spurious: assert property (!param_rd |=> !param_rvalid)
    else $error("read valid without a read");
  chk_rdata_idle: assert property (!param_rvalid |-> param_rdata == 16'h0000)
    else $error("read data not zero outside a read");
  chk_reserved_zero: assert property (param_rvalid && $past(param_addr) == `LWSW_ADDR_SAVED_WARNING
    |-> !param_rdata[15] && !param_rdata[3])
    else $error("reserved bit set");
  chk_write_refused: assert property (param_wr && !param_rd && is_map |=> param_wr_refused && !param_err)
    else $error("write to status word not refused");
  chk_unmapped_err: assert property ((param_rd ^ param_wr) && !is_map |=> param_err && param_rdata == 16'h0000)
    else $error("unmapped access not flagged");
  chk_torque_off_sets: assert property (torque_off_on ##0 rd_saved |=> param_rdata[10])
    else $error("torque off bit not set");
  chk_pos_clears: assert property (pos_gone ##0 rd_saved |=> !param_rdata[13])
    else $error("position bit did not clear");
endmodule
bind lwsw_top lwsw_monitor mon_u (.clock, .rst, .safe_torque_off_input_a_n, .position_not_valid, .param_rd,
  .param_wr, .param_addr, .param_rdata, .param_rvalid, .param_err, .param_wr_refused);

// ### tb/lwsw_fieldbus_master.sv
// fieldbus master model issuing single parameter accesses
// assumes: answer registered one cycle after the request edge
`timescale 1ns/1ps
module lwsw_fieldbus_master (
  input wire logic clock,
  input wire logic [15:0] param_rdata,
  input wire logic param_rvalid,
  input wire logic param_err,
  input wire logic param_wr_refused,
  output logic param_rd,
  output logic param_wr,
  output logic [15:0] param_addr,
  output logic [15:0] param_wdata
);
  initial begin
    param_rd = 1'b0;
    param_wr = 1'b0;
    param_addr = 16'h0000;
    param_wdata = 16'h0000;
  end
  // ==========================================================
  // one access; released lines show the inverse, not the old value
  task automatic xfer(input logic w, input logic [15:0] a, output logic [15:0] d, output logic [2:0] f);
    @(posedge clock);
    param_rd <= !w;
    param_wr <= w;
    param_addr <= a;
    param_wdata <= ~a;
    @(posedge clock);
    param_rd <= 1'b0;
    param_wr <= 1'b0;
    param_addr <= ~a;
    param_wdata <= a;
    #1;
    d = param_rdata;
    f = {param_rvalid, param_err, param_wr_refused};
  endtask
endmodule

// ### tb/latched_warning_status_word_tb_top.sv
// testbench for the warning status block
// assumes: master model drives the parameter port; src index is the saved bit, except src[3] (bit 10) and src[15] (bit 11)
`timescale 1ns/1ps
`include "lwsw_map.svh"
module latched_warning_status_word_tb_top;
  logic clock, rst, fault_reset_request, standstill, rotate_cw, rotate_ccw;
  logic [15:0] src, exp, d;
  logic [3:0] error_class;
  logic [1:0] profile_state;
  logic [2:0] f;
  logic param_rd, param_wr, param_rvalid, param_err, param_wr_refused;
  logic [15:0] param_addr, param_wdata, param_rdata;
  int errors, total_checks;
  int cyc = 0;
  int sc_src[5] = '{10, 3, 11, 15, 13};
  int sc_bit[5] = '{10, 10, 11, 11, 13};
  // src[3] and src[15] stand in for the second source of bits 10 and 11
  lwsw_top dut_u (.clock, .rst, .general_warn(src[0]), .stage_temp_high(src[1]), .motor_temp_high(src[2]),
    .stage_overload(src[4]), .motor_overload(src[5]), .brake_overload(src[6]), .can_warn(src[7]),
    .encoder_warn(src[8]), .rs485_warn(src[9]), .safe_torque_off_input_a_n(~src[10]),
    .safe_torque_off_input_b_n(~src[3]), .dc_undervoltage(src[11]), .mains_phase_missing(src[15]),
    .profibus_warn(src[12]), .position_not_valid(src[13]), .ethernet_warn(src[14]), .fault_reset_request,
    .error_class, .standstill, .rotate_cw, .rotate_ccw, .profile_state, .param_rd, .param_wr, .param_addr,
    .param_wdata, .param_rdata, .param_rvalid, .param_err, .param_wr_refused);
  lwsw_fieldbus_master mst_u (.clock, .param_rdata, .param_rvalid, .param_err, .param_wr_refused,
    .param_rd, .param_wr, .param_addr, .param_wdata);
  // ==========================================================
  // compare, access and verdict
  task chk(input logic [15:0] seen, input logic [15:0] want);
    total_checks++;
    if (seen !== want) begin
      errors++;
      $display("unexpected at %0t: got %h want %h", $time, seen, want);
    end
  endtask
  task acc(input logic w, input logic [15:0] a, input logic [15:0] want, input logic [2:0] wf);
    mst_u.xfer(w, a, d, f);
    chk(d, want);
    chk({13'h0000, f}, {13'h0000, wf});
  endtask
  task test_done();
    $display("checks %0d mismatches %0d", total_checks, errors);
    if (errors == 0 && total_checks > 0) begin
      $display("*** PASS ***");
    end else begin
      $display("*** FAIL ***");
    end
    $finish;
  endtask
  // ==========================================================
  // clock and hang guard, the tests need well under 1000 cycles
  initial begin
    clock = 1'b0;
    forever #12.5 clock = ~clock;
  end
  always @(posedge clock) begin
    cyc <= cyc + 1;
    if (cyc == 2000) begin
      errors++;
      test_done();
    end
  end
  // ==========================================================
  // main sequence
  initial begin
    rst = 1'b1;
    src = 16'h0000;
    fault_reset_request = 1'b0;
    standstill = 1'b0;
    rotate_cw = 1'b0;
    rotate_ccw = 1'b0;
    error_class = 4'h0;
    profile_state = 2'h0;
    errors = 0;
    total_checks = 0;
    repeat (5) @(posedge clock);
    rst <= 1'b0;
    repeat (5) @(posedge clock);
    acc(0, `LWSW_ADDR_SAVED_WARNING, 16'h0000, 3'h4);
    acc(0, `LWSW_ADDR_ACTION_STATUS, 16'h0800, 3'h4);
    $display("reset test done");
    exp = 16'h0000;
    for (int i = 0; i < 15; i++) begin
      if (!(i inside {3, 10, 11, 13})) begin
        @(posedge clock);
        src[i] <= 1'b1;
        repeat (5) @(posedge clock);
        src[i] <= 1'b0;
        exp[i] = 1'b1;
        acc(0, `LWSW_ADDR_SAVED_WARNING, exp, 3'h4);
      end
    end
    acc(1, `LWSW_ADDR_SAVED_WARNING, 16'h0000, 3'h1);
    acc(1, `LWSW_ADDR_ACTION_STATUS, 16'h0000, 3'h1);
    acc(0, `LWSW_ADDR_SAVED_WARNING, exp, 3'h4);
    acc(0, 16'h1c10, 16'h0000, 3'h6);
    acc(1, 16'h1c10, 16'h0000, 3'h2);
    @(posedge clock);
    fault_reset_request <= 1'b1;
    repeat (5) @(posedge clock);
    acc(0, `LWSW_ADDR_SAVED_WARNING, 16'h0000, 3'h4);
    $display("latch test done");
    for (int k = 0; k < 5; k++) begin
      @(posedge clock);
      src[sc_src[k]] <= 1'b1;
      repeat (5) @(posedge clock);
      acc(0, `LWSW_ADDR_SAVED_WARNING, 16'h0001 << sc_bit[k], 3'h4);
      acc(0, `LWSW_ADDR_ACTION_STATUS, 16'h0801, 3'h4);
      @(posedge clock);
      src[sc_src[k]] <= 1'b0;
      repeat (5) @(posedge clock);
      acc(0, `LWSW_ADDR_SAVED_WARNING, 16'h0000, 3'h4);
    end
    $display("self clear test done");
    @(posedge clock);
    error_class <= 4'ha;
    standstill <= 1'b1;
    rotate_ccw <= 1'b1;
    for (int p = 0; p < 4; p++) begin
      @(posedge clock);
      profile_state <= p[1:0];
      rotate_cw <= p[0];
      repeat (5) @(posedge clock);
      acc(0, `LWSW_ADDR_ACTION_STATUS, (16'h0800 << p) | (p[0] ? 16'h01d4 : 16'h0154), 3'h4);
    end
    $display("action test done");
    test_done();
  end
endmodule
